// file: verilog/alarm_map_pkg.sv
/*
 * Constants and carrier types for the transceiver alarm register map.
 * Assumes a single 100 MHz core clock.
 */
package alarm_map_pkg;
   localparam int          ADDR_W          = 6;
   localparam int          DATA_W          = 8;
   localparam int          FRAME_BITS      = 16;
   localparam int          NUM_SRC         = 5;
   // Register offsets
   localparam logic [5:0]  OFS_IRQ_ENABLE  = 6'h00;
   localparam logic [5:0]  OFS_IRQ_STATUS  = 6'h01;
   localparam logic [5:0]  OFS_LIVE_STATUS = 6'h02;
   localparam logic [5:0]  OFS_CLOCK_FIFO  = 6'h03;
   localparam logic [5:0]  OFS_TIMING_POL  = 6'h04;
   localparam logic [5:0]  OFS_LOOPBACK    = 6'h05;
   localparam logic [5:0]  OFS_DEVICE_IDENTITY   = 6'h3E;
   localparam logic [5:0]  OFS_REVISION_IDENTITY = 6'h3F;
   // Field positions shared by enable, status and live registers; the detect enable bit is in the timing register
   localparam int          BIT_OSC_LOCK    = 4;
   localparam int          BIT_SIG_LOSS    = 3;
   localparam int          BIT_RECOVERY    = 2;
   localparam int          BIT_MULTIPLIER  = 1;
   localparam int          BIT_OVERFLOW    = 0;
   localparam int          BIT_OSC_DET_EN  = 0;
   // Reset values and writable-bit masks
   localparam logic [4:0]  RST_ALARM       = 5'h00;
   localparam logic [7:0]  RST_CLOCK_FIFO  = 8'h40;
   localparam logic [7:0]  RST_TIMING_POL  = 8'h00;
   localparam logic [7:0]  RST_LOOPBACK    = 8'h00;
   localparam logic [7:0]  CLOCK_FIFO_MASK = 8'h5F;
   localparam logic [7:0]  TIMING_POL_MASK = 8'h7D;
   localparam logic [7:0]  LOOPBACK_MASK   = 8'h07;
   // Identity codes, values arbitrary
   localparam logic [7:0]  DEVICE_IDENTITY_VAL   = 8'hA5;
   localparam logic [7:0]  REVISION_IDENTITY_VAL = 8'h01;

   // The five monitored conditions
   typedef struct packed {
      logic osc_lock;
      logic signal_loss;
      logic recovery_lock;
      logic multiplier_lock;
      logic overflow;
   } alarm_src_t;

   // Control outputs of the configuration registers
   typedef struct packed {
      logic [7:0] clock_fifo;
      logic [7:0] timing_polarity;
      logic [7:0] loopback;
   } config_out_t;
endpackage

// file: verilog/transceiver_alarm_register_map.sv
/*
 * Alarm and control register map reached over a 16-bit serial control frame
 * (write/read flag, six address bits, a dummy bit, eight data bits, all LSB
 * first, sampled on the rising serial clock, committed when chip select rises).
 * Assumes serial pins are asynchronous to core_clk and much slower than it;
 * the condition inputs come from analog blocks and are asynchronous too.
 */
// Summary of operation
// - Registers alarm_irq_enable to loopback_config of the 64-entry space hold the control and status.
// - Register alarm_irq_enable holds five interrupt enables at bits 4 down to 0.
// - An enable of zero blocks its source, one permits it, and all reset to zero.
// - Register alarm_irq_status holds the five latched status bits in the enable positions.
// - A status bit sets on a change of its condition in either direction, reset zero.
// - The interrupt pin is driven only for a set status bit whose enable is one.
// - The live oscillator lock bit and its interrupt stay inactive unless bit 0 of register timing_polarity_config is set.
// - Location 0x3E returns a fixed device identity byte and ignores writes.
// - Location 0x3F returns a fixed revision identity byte and ignores writes.
// - Register alarm_live_status shows the live state of the five conditions.
`timescale 1ns/1ns
module transceiver_alarm_register_map
   import alarm_map_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        srst,
   // Serial control port
   input  wire logic        cs_n,
   input  wire logic        sclk,
   input  wire logic        sdi,
   output logic             sdo,
   output logic             sdo_oe,
   // Condition inputs from the analog blocks
   input  wire alarm_map_pkg::alarm_src_t alarm_in,
   // Interrupt pin and configuration outputs
   output logic             irq,
   output alarm_map_pkg::config_out_t cfg_out
);
   import alarm_map_pkg::*;

   // Refuse package constants that the frame decoder cannot serve
   if (FRAME_BITS != 16 || NUM_SRC != 5) begin : g_bad_config
      $error("Unsupported frame or source count");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   logic [2:0]  ser_meta_q;
   logic [2:0]  ser_sync_q;
   logic [4:0]  src_meta_q;
   logic [4:0]  src_sync_q;
   logic        sclk_prev_q;
   logic        cs_prev_q;

   // Two flops on every serial pin before use
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ser_meta_q <= 3'h7;
         ser_sync_q <= 3'h7;
      end else begin
         ser_meta_q <= {cs_n, sclk, sdi};
         ser_sync_q <= ser_meta_q;
      end
   end

   // Condition synchroniser runs through reset, so its level is valid at release
   always_ff @(posedge core_clk) begin
      src_meta_q <= alarm_in;
      src_sync_q <= src_meta_q;
   end

   logic cs_n_s;
   logic sclk_s;
   logic sdi_s;
   assign cs_n_s = ser_sync_q[2];
   assign sclk_s = ser_sync_q[1];
   assign sdi_s  = ser_sync_q[0];

   // Edge history of the synchronised serial lines
   always_ff @(posedge core_clk) begin
      if (srst) begin
         sclk_prev_q <= 1'b0;
         cs_prev_q   <= 1'b1;
      end else begin
         sclk_prev_q <= sclk_s;
         cs_prev_q   <= cs_n_s;
      end
   end

   logic sclk_rise;
   logic sclk_fall;
   logic cs_rise;
   assign sclk_rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
   assign sclk_fall = ~sclk_s & sclk_prev_q & ~cs_n_s;
   assign cs_rise   = cs_n_s & ~cs_prev_q;

   ////////////////////////////////////////////////////////////////////////////
   // Serial frame capture
   logic [15:0] shift_q;
   logic [4:0]  bit_cnt_q;
   logic        rd_done_q;

   // Shift in LSB first; frame is complete at 16 bits
   always_ff @(posedge core_clk) begin
      if (srst || cs_n_s) begin
         shift_q   <= 16'h0000;
         bit_cnt_q <= 5'h00;
      end else if (sclk_rise && bit_cnt_q != 5'h10) begin
         shift_q   <= {sdi_s, shift_q[15:1]};
         bit_cnt_q <= bit_cnt_q + 5'h01;
      end
   end

   logic        frame_full;
   logic        f_read;
   logic [5:0]  f_addr;
   logic [7:0]  f_data;
   logic [5:0]  hdr_addr;
   assign frame_full = (bit_cnt_q == 5'h10);
   assign f_read     = shift_q[0];
   assign f_addr     = shift_q[6:1];
   assign f_data     = shift_q[15:8];
   // Address as it sits in the shifter after 7 bits
   assign hdr_addr   = shift_q[15:10];

   // Write commits only after all 16 bits and chip select release
   logic wr_commit;
   assign wr_commit = cs_rise && frame_full && !f_read;

   ////////////////////////////////////////////////////////////////////////////
   // Control registers
   logic [4:0]  irq_en_q;
   logic [7:0]  clock_fifo_q;
   logic [7:0]  timing_pol_q;
   logic [7:0]  loopback_q;

   // Writes to the configuration space; identity locations ignore writes
   always_ff @(posedge core_clk) begin
      if (srst) begin
         irq_en_q     <= RST_ALARM;
         clock_fifo_q <= RST_CLOCK_FIFO;
         timing_pol_q <= RST_TIMING_POL;
         loopback_q   <= RST_LOOPBACK;
      end else if (wr_commit) begin
         if (f_addr == OFS_IRQ_ENABLE) begin
            irq_en_q <= f_data[4:0];
         end else if (f_addr == OFS_CLOCK_FIFO) begin
            clock_fifo_q <= f_data & CLOCK_FIFO_MASK;
         end else if (f_addr == OFS_TIMING_POL) begin
            timing_pol_q <= f_data & TIMING_POL_MASK;
         end else if (f_addr == OFS_LOOPBACK) begin
            loopback_q <= f_data & LOOPBACK_MASK;
         end
      end
   end

   logic osc_det_en;
   assign osc_det_en = timing_pol_q[BIT_OSC_DET_EN];

   ////////////////////////////////////////////////////////////////////////////
   // Live conditions and change detection
   logic [4:0]  live;
   logic [4:0]  live_prev_q;
   logic [4:0]  change;

   // Oscillator lock reads inactive while its detector is disabled
   always_comb begin
      live = src_sync_q;
      live[BIT_OSC_LOCK] = src_sync_q[BIT_OSC_LOCK] & osc_det_en;
   end

   // History follows the live state in reset too, so a condition that is
   // already present at release is not taken for a change
   always_ff @(posedge core_clk) begin
      live_prev_q <= live;
   end

   assign change = live ^ live_prev_q;

   ////////////////////////////////////////////////////////////////////////////
   // Read data path
   logic [7:0]  rd_data_q;
   logic [4:0]  status_q;
   logic [4:0]  rd_clear_q;
   logic        rd_latch;

   // Latch read data when the dummy bit arrives
   assign rd_latch = sclk_rise && bit_cnt_q == 5'h07 && shift_q[9];

   function automatic logic [7:0] read_mux(input logic [5:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (a == OFS_IRQ_ENABLE) begin
         v = {3'h0, irq_en_q};
      end else if (a == OFS_IRQ_STATUS) begin
         v = {3'h0, status_q};
      end else if (a == OFS_LIVE_STATUS) begin
         v = {3'h0, live};
      end else if (a == OFS_CLOCK_FIFO) begin
         v = clock_fifo_q;
      end else if (a == OFS_TIMING_POL) begin
         v = timing_pol_q;
      end else if (a == OFS_LOOPBACK) begin
         v = loopback_q;
      end else if (a == OFS_DEVICE_IDENTITY) begin
         v = DEVICE_IDENTITY_VAL;
      end else if (a == OFS_REVISION_IDENTITY) begin
         v = REVISION_IDENTITY_VAL;
      end
      return v;
   endfunction

   // Snapshot of the word to shift out, and which status bits it returned
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rd_data_q  <= 8'h00;
         rd_clear_q <= 5'h00;
         rd_done_q  <= 1'b0;
      end else if (cs_n_s) begin
         rd_done_q  <= 1'b0;
         rd_clear_q <= 5'h00;
      end else if (rd_latch) begin
         rd_data_q  <= read_mux(hdr_addr);
         rd_done_q  <= 1'b1;
         rd_clear_q <= (hdr_addr == OFS_IRQ_STATUS) ? status_q : 5'h00;
      end else if (sclk_fall && rd_done_q && bit_cnt_q >= 5'h09) begin
         rd_data_q <= {1'b0, rd_data_q[7:1]};
      end
   end

   // Status cleared once the read frame closes
   logic [4:0] clr_mask;
   assign clr_mask = (cs_rise && frame_full && f_read) ? rd_clear_q : 5'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Sticky status; a change in the clearing cycle wins
   always_ff @(posedge core_clk) begin
      if (srst) begin
         status_q <= RST_ALARM;
      end else begin
         status_q <= (status_q & ~clr_mask) | change;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial output and interrupt pin
   logic [4:0] pend;
   always_comb begin
      pend = status_q & irq_en_q;
      if (!osc_det_en) begin
         pend[BIT_OSC_LOCK] = 1'b0;
      end
   end

   // True once the header and dummy bit have been taken
   function automatic logic f_read_hdr_ok(input logic [4:0] n);
      return (n >= 5'h08);
   endfunction

   // Registered pin drivers
   always_ff @(posedge core_clk) begin
      if (srst) begin
         irq    <= 1'b0;
         sdo    <= 1'b0;
         sdo_oe <= 1'b0;
      end else begin
         irq    <= |pend;
         sdo    <= rd_data_q[0];
         sdo_oe <= rd_done_q && f_read_hdr_ok(bit_cnt_q);
      end
   end

   // Configuration outputs straight from registers
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cfg_out <= {RST_CLOCK_FIFO, RST_TIMING_POL, RST_LOOPBACK};
      end else begin
         cfg_out <= {clock_fifo_q, timing_pol_q, loopback_q};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_irq_follows_pend: assert property (@(posedge core_clk) disable iff (srst)
      ((|pend) |=> irq)) else $error("Interrupt not raised for pending source");
   a_irq_drops_clear: assert property (@(posedge core_clk) disable iff (srst)
      (!(|pend) |=> !irq)) else $error("Interrupt held with nothing pending");
   a_change_sets_status: assert property (@(posedge core_clk) disable iff (srst)
      (change[BIT_OVERFLOW] |=> status_q[BIT_OVERFLOW])) else $error("Change lost");
   a_status_holds: assert property (@(posedge core_clk) disable iff (srst)
      ((clr_mask == 5'h00) && (change == 5'h00) |=> status_q == $past(status_q)))
      else $error("Status moved without cause");
   a_read_clears: assert property (@(posedge core_clk) disable iff (srst)
      ((clr_mask != 5'h00) && (change == 5'h00) |=> ((status_q & $past(clr_mask)) == 5'h00)))
      else $error("Status not cleared by read");
   a_osc_gated: assert property (@(posedge core_clk) disable iff (srst)
      (!osc_det_en && ((status_q & irq_en_q & 5'h0F) == 5'h00) |=> !irq))
      else $error("Oscillator bit active while detector off");
   a_enable_write: assert property (@(posedge core_clk) disable iff (srst)
      (wr_commit && f_addr == OFS_IRQ_ENABLE |=> irq_en_q == $past(f_data[4:0])))
      else $error("Enable write not stored");
   a_no_early_write: assert property (@(posedge core_clk) disable iff (srst)
      (!cs_rise |=> irq_en_q == $past(irq_en_q)))
      else $error("Enable changed outside frame end");
endmodule

// file: sim/host_serial_model.sv
/*
 * Host side of the 16-bit serial control port: one frame per chip-select.
 * Assumes core_clk is free running; all pins change just after its rising edge.
 */
`timescale 1ns/1ns
module host_serial_model
   import alarm_map_pkg::*;
#(
   parameter int HALF = 8
)
(
   // Clock
   input  wire logic core_clk,
   // Serial control port
   output logic      cs_n,
   output logic      sclk,
   output logic      sdi,
   input  wire logic sdo,
   input  wire logic sdo_oe
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      sdi  = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // One frame, LSB first; a read bit counts only while sdo is enabled
   task automatic frame(input logic rw, input logic [5:0] a, input logic [7:0] wd,
                        input int nbits, output logic [7:0] rdata);
      logic [15:0] bits;
      bits  = {wd, 1'b0, a, rw};
      rdata = 8'h00;
      @(posedge core_clk) cs_n <= 1'b0;
      for (int i = 0; i < nbits; i++) begin
         @(posedge core_clk) sclk <= 1'b0;
         sdi <= bits[i];
         repeat (HALF - 1) @(posedge core_clk);
         if (i >= 8) rdata[i-8] = sdo_oe ? sdo : 1'bx;
         @(posedge core_clk) sclk <= 1'b1;
         repeat (HALF - 1) @(posedge core_clk);
      end
      // Clock stands low, data line no longer holds the last bit
      @(posedge core_clk) sclk <= 1'b0;
      sdi <= ~sdi;
      repeat (HALF) @(posedge core_clk);
      @(posedge core_clk) cs_n <= 1'b1;
      repeat (2 * HALF) @(posedge core_clk);
   endtask
endmodule

// file: sim/tb.sv
/*
 * Self-checking bench for the alarm register map.
 * Assumes the host model above drives every serial frame.
 */
`timescale 1ns/1ns
module tb;
   import alarm_map_pkg::*;
   typedef struct {logic [5:0] a; logic [7:0] w; logic [7:0] e;} row_t;
   logic        core_clk = 1'b0;
   logic        srst     = 1'b1;
   logic        cs_n, sclk, sdi, sdo, sdo_oe, irq;
   alarm_src_t  alarm_in = 5'h00;
   config_out_t cfg_out;
   int          fails = 0;
   int          checks = 0;
   int          cycles = 0;
   logic [7:0]  v;
   row_t        rows [8] = '{'{6'h00, 8'hFF, 8'h1F}, '{6'h03, 8'hFF, 8'h5F},
                             '{6'h04, 8'hFE, 8'h7C}, '{6'h05, 8'hFF, 8'h07},
                             '{6'h3E, 8'h00, 8'hA5}, '{6'h3F, 8'h00, 8'h01},
                             '{6'h02, 8'hFF, 8'h00}, '{6'h2A, 8'hFF, 8'h00}};

   always #5 core_clk = ~core_clk;

   transceiver_alarm_register_map transceiver_alarm_register_map_inst (
      .core_clk(core_clk), .srst(srst), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
      .sdo(sdo), .sdo_oe(sdo_oe), .alarm_in(alarm_in), .irq(irq), .cfg_out(cfg_out));
   host_serial_model host_serial_model_inst (
      .core_clk(core_clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));

   ////////////////////////////////////////////////////////////////////////////
   // Comparison, bus access, closing and reset tasks
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      host_serial_model_inst.frame(1'b0, a, d, 16, v);
   endtask
   task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
      host_serial_model_inst.frame(1'b1, a, 8'h00, 16, v);
      check({16'h0000, v}, {16'h0000, e});
   endtask
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic do_reset();
      @(posedge core_clk) srst <= 1'b1;
      repeat (16) @(posedge core_clk);
      srst <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask

   // Hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         conclude();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      do_reset();
      // Table: write, then read back the masked or fixed value
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd_chk(rows[i].a, rows[i].e);
      end
      check(cfg_out, 24'h5F7C07);
      // Both edges of a condition latch status; the rise raises the pin, the fall with enables off does not
      @(posedge core_clk) alarm_in <= 5'h09;
      repeat (10) @(posedge core_clk);
      check({23'h0, irq}, 24'h1);
      rd_chk(OFS_LIVE_STATUS, 8'h09);
      rd_chk(OFS_IRQ_STATUS, 8'h09);
      repeat (10) @(posedge core_clk);
      check({23'h0, irq}, 24'h0);
      rd_chk(OFS_IRQ_STATUS, 8'h00);
      wr(OFS_IRQ_ENABLE, 8'h00);
      @(posedge core_clk) alarm_in <= 5'h00;
      repeat (10) @(posedge core_clk);
      check({23'h0, irq}, 24'h0);
      rd_chk(OFS_IRQ_STATUS, 8'h09);
      wr(OFS_IRQ_ENABLE, 8'h1F);
      // Oscillator lock is inert until its detect enable is set
      @(posedge core_clk) alarm_in <= 5'h10;
      repeat (10) @(posedge core_clk);
      rd_chk(OFS_LIVE_STATUS, 8'h00);
      rd_chk(OFS_IRQ_STATUS, 8'h00);
      wr(OFS_TIMING_POL, 8'h01);
      check({23'h0, irq}, 24'h1);
      rd_chk(OFS_LIVE_STATUS, 8'h10);
      rd_chk(OFS_IRQ_STATUS, 8'h10);
      // Turning the detector off latches the drop but raises no interrupt
      wr(OFS_TIMING_POL, 8'h00);
      check({23'h0, irq}, 24'h0);
      rd_chk(OFS_IRQ_STATUS, 8'h10);
      // A short frame commits nothing
      wr(OFS_LOOPBACK, 8'h02);
      host_serial_model_inst.frame(1'b0, OFS_LOOPBACK, 8'h05, 15, v);
      rd_chk(OFS_LOOPBACK, 8'h02);
      // Second reset restores defaults; a condition held across it is no change
      @(posedge core_clk) alarm_in <= 5'h04;
      do_reset();
      rd_chk(OFS_LIVE_STATUS, 8'h04);
      check(cfg_out, {RST_CLOCK_FIFO, RST_TIMING_POL, RST_LOOPBACK});
      check({23'h0, irq}, 24'h0);
      rd_chk(OFS_IRQ_ENABLE, 8'h00);
      rd_chk(OFS_IRQ_STATUS, 8'h00);
      conclude();
   end
endmodule
